// ---- hw/sbio_port.v ----
// six pin bidirectional general purpose port with alternate functions
`timescale 1ns/1ns
`default_nettype none
`include "sbio_map.vh"
module sbio_port (
  input  wire       clock_i,
  input  wire       reset_n_i,
  input  wire [5:0] io_addr_i,
  input  wire       io_wr_i,
  input  wire       io_rd_i,
  input  wire [7:0] io_wdata_i,
  output wire [7:0] io_rdata_o,
  output wire       io_hit_o,
  input  wire       bit_set_instruction_i,
  input  wire       bit_clear_instruction_i,
  input  wire [2:0] bit_index_i,
  input  wire       global_pullup_disable_i,
  input  wire       reset_pin_disable_fuse_i,
  input  wire       serial_prog_mode_i,
  input  wire       sleep_analog_quiet_i,
  input  wire       timer_one_compare_en_i,
  input  wire       timer_one_compare_val_i,
  input  wire       serial_data_out_i,
  input  wire       serial_data_out_en_i,
  input  wire [5:0] pad_in_i,
  output wire [5:0] pad_out_o,
  output wire [5:0] pad_oe_o,
  output wire [5:0] pad_pullup_o,
  output wire [5:0] pin_change_o,
  output wire       ext_reset_n_o,
  output wire       ext_irq_zero_input_o,
  output wire       counter_zero_clock_input_o,
  output wire       serial_clock_o,
  output wire       serial_data_in_o,
  output wire       comparator_pos_input_o,
  output wire       comparator_neg_input_o,
  output wire       converter_ref_pin_o
);

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg  [5:0] dir_q;
  wire [5:0] dir_d;
  reg  [4:0] latch_q;
  wire [4:0] latch_d;
  wire [7:0] bit_mask;
  wire       sel_dir;
  wire       sel_latch;
  wire       sel_level;
  wire       wr_dir;
  wire       wr_latch;
  wire       set_dir;
  wire       clr_dir;
  wire       set_latch;
  wire       clr_latch;
  wire       dir_idx_ok;
  wire       latch_idx_ok;

  assign sel_dir   = (io_addr_i == `SBIO_DIR_ADDR);
  assign sel_latch = (io_addr_i == `SBIO_LATCH_ADDR);
  assign sel_level = (io_addr_i == `SBIO_LEVEL_ADDR);
  assign bit_mask  = 8'h01 << bit_index_i;
  assign io_hit_o  = sel_dir | sel_latch | sel_level;

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  assign dir_idx_ok   = (bit_index_i < 3'h6);
  assign latch_idx_ok = (bit_index_i < 3'h5);
  assign wr_dir       = io_wr_i & sel_dir;
  assign wr_latch     = io_wr_i & sel_latch;
  assign set_dir      = bit_set_instruction_i & sel_dir & dir_idx_ok;
  assign clr_dir      = bit_clear_instruction_i & sel_dir & dir_idx_ok;
  assign set_latch    = bit_set_instruction_i & sel_latch & latch_idx_ok;
  assign clr_latch    = bit_clear_instruction_i & sel_latch & latch_idx_ok;

  // bit ops touch one bit only, so no other pin moves mid-update;
  // clear beats set, and a bit op beats a byte write on its own bit
  genvar r;
  generate
    for (r = 0; r < `SBIO_PIN_CNT; r = r + 1) begin : g_reg_bit
      reg dir_nxt;
      always @* begin
        case ({clr_dir & bit_mask[r], set_dir & bit_mask[r], wr_dir})
          3'b000: begin
            dir_nxt = dir_q[r];
          end
          3'b001: begin
            dir_nxt = io_wdata_i[r];
          end
          3'b010, 3'b011: begin
            dir_nxt = 1'b1;
          end
          default: begin
            dir_nxt = 1'b0;
          end
        endcase
      end
      assign dir_d[r] = dir_nxt;
      if (r < `SBIO_PAD_RESET) begin : g_latch
        reg latch_nxt;
        always @* begin
          case ({clr_latch & bit_mask[r], set_latch & bit_mask[r],
                 wr_latch})
            3'b000: begin
              latch_nxt = latch_q[r];
            end
            3'b001: begin
              latch_nxt = io_wdata_i[r];
            end
            3'b010, 3'b011: begin
              latch_nxt = 1'b1;
            end
            default: begin
              latch_nxt = 1'b0;
            end
          endcase
        end
        assign latch_d[r] = latch_nxt;
      end
    end
  endgenerate

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dir_q   <= `SBIO_DIR_RST;
      latch_q <= `SBIO_LATCH_RST;
    end else begin
      dir_q   <= dir_d;
      latch_q <= latch_d;
    end
  end

  // ------------------------------------------------------------
  // pad input path
  // ------------------------------------------------------------
  // quiet sleep forces analog pins low instead of letting them float
  wire [5:0] pad_level;
  wire [5:0] in_enable;
  reg  [5:0] level_q;

  assign in_enable = sleep_analog_quiet_i ? ~`SBIO_ANALOG_MASK
                                          : 6'h3f;
  assign pad_level = pad_in_i & in_enable;

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_q <= 6'h00;
    end else begin
      level_q <= pad_level;
    end
  end

  // no compare until level_q holds a real sample, else reset fakes
  // an edge on every pad that idles high
  reg        armed_q;
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  // change seen as a one cycle pulse per pin
  assign pin_change_o = armed_q ? (pad_level ^ level_q)
                                : 6'h00;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  reg  [7:0] rdata_d;
  reg  [7:0] rdata_q;

  // unmapped reads return zero, never stale data
  always @* begin
    rdata_d = rdata_q;
    if (io_rd_i) begin
      if (sel_dir) begin
        rdata_d = {2'b00, dir_q};
      end else if (sel_latch) begin
        rdata_d = {3'b000, latch_q};
      end else if (sel_level) begin
        rdata_d = {2'b00, pad_level};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign io_rdata_o = rdata_q;

  // ------------------------------------------------------------
  // pad drivers, one mode per pin
  // ------------------------------------------------------------
  localparam [2:0] PM_FLOAT  = 3'h0;
  localparam [2:0] PM_PULLUP = 3'h1;
  localparam [2:0] PM_LOW    = 3'h2;
  localparam [2:0] PM_HIGH   = 3'h3;
  localparam [2:0] PM_SINK   = 3'h4;
  localparam [2:0] PM_RESET  = 3'h5;

  wire [5:0] latch_x;
  wire [5:0] gp_oe;
  wire [5:0] gp_out;
  assign latch_x = {1'b0, latch_q};

  // pad five has no high driver and no pull-up, so it only sinks
  genvar g;
  generate
    for (g = 0; g < `SBIO_PIN_CNT; g = g + 1) begin : g_pin
      reg [2:0] mode;
      reg       oe;
      reg       out;
      reg       pu;
      always @* begin
        mode = PM_FLOAT;
        if (g == `SBIO_PAD_RESET) begin
          if (!reset_pin_disable_fuse_i) begin
            mode = PM_RESET;
          end else if (dir_q[g]) begin
            mode = PM_SINK;
          end else begin
            mode = PM_FLOAT;
          end
        end else if (dir_q[g]) begin
          mode = latch_x[g] ? PM_HIGH : PM_LOW;
        end else if (latch_x[g] && !global_pullup_disable_i) begin
          mode = PM_PULLUP;
        end else begin
          mode = PM_FLOAT;
        end
      end
      always @* begin
        case (mode)
          PM_PULLUP: begin
            oe  = 1'b0;
            out = 1'b0;
            pu  = 1'b1;
          end
          PM_LOW: begin
            oe  = 1'b1;
            out = 1'b0;
            pu  = 1'b0;
          end
          PM_HIGH: begin
            oe  = 1'b1;
            out = 1'b1;
            pu  = 1'b0;
          end
          PM_SINK: begin
            oe  = 1'b1;
            out = 1'b0;
            pu  = 1'b0;
          end
          default: begin
            oe  = 1'b0;
            out = 1'b0;
            pu  = 1'b0;
          end
        endcase
      end
      assign gp_oe[g]        = oe;
      assign gp_out[g]       = out;
      assign pad_pullup_o[g] = pu;
    end
  endgenerate

  // ------------------------------------------------------------
  // pad one and pad zero overrides
  // ------------------------------------------------------------
  wire pad1_oe;
  wire pad1_out;
  wire pad0_oe;
  reg  pad1_alt_out;
  always @* begin
    case ({serial_prog_mode_i, timer_one_compare_en_i})
      2'b00: begin
        pad1_alt_out = gp_out[1];
      end
      2'b01: begin
        pad1_alt_out = timer_one_compare_val_i;
      end
      default: begin
        pad1_alt_out = serial_data_out_i;
      end
    endcase
  end
  assign pad1_out = pad1_alt_out;
  assign pad1_oe  = serial_prog_mode_i ? serial_data_out_en_i
                                       : gp_oe[1];
  // pad zero is the serial data input while programming
  assign pad0_oe  = serial_prog_mode_i ? 1'b0 : gp_oe[0];

  assign pad_out_o = {gp_out[5:2], pad1_out, gp_out[0]};
  assign pad_oe_o  = {gp_oe[5:2], pad1_oe, pad0_oe};

  // ------------------------------------------------------------
  // external reset
  // ------------------------------------------------------------
  assign ext_reset_n_o = reset_pin_disable_fuse_i ? 1'b1
                                                  : pad_in_i[5];

  // ------------------------------------------------------------
  // alternate inputs, read from pad regardless of direction
  // ------------------------------------------------------------
  // pad two feeds irq and counter even while it drives
  assign serial_clock_o             = serial_prog_mode_i & pad_in_i[2];
  assign ext_irq_zero_input_o       = ~serial_prog_mode_i
                                      & pad_level[2];
  assign counter_zero_clock_input_o = pad_level[2];
  assign serial_data_in_o           = serial_prog_mode_i & pad_in_i[0];
  assign comparator_neg_input_o     = pad_in_i[1];
  assign comparator_pos_input_o     = pad_in_i[0];
  assign converter_ref_pin_o        = pad_in_i[0];

endmodule // sbio_port
`default_nettype wire

// ---- include/sbio_map.vh ----
// register offsets, reset values and pin positions for the six pin port
`ifndef SBIO_MAP_VH
`define SBIO_MAP_VH
`define SBIO_ADDR_W            6
`define SBIO_LEVEL_ADDR        6'h16
`define SBIO_DIR_ADDR          6'h17
`define SBIO_LATCH_ADDR        6'h18
`define SBIO_DIR_RST           6'h00
`define SBIO_LATCH_RST         5'h00
`define SBIO_PIN_CNT           6
`define SBIO_PAD_RESET         5
`define SBIO_PAD_SCK           2
`define SBIO_PAD_MISO          1
`define SBIO_PAD_MOSI          0
`define SBIO_ANALOG_MASK       6'h3c
`endif

// ---- testbench/sbio_port_asserts.sv ----
// concurrent checks on the six pin port
`timescale 1ns/1ns
`default_nettype none
module sbio_port_asserts (
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic [5:0] io_addr_i,
  input wire logic       io_rd_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic       global_pullup_disable_i,
  input wire logic       reset_pin_disable_fuse_i,
  input wire logic       sleep_analog_quiet_i,
  input wire logic [5:0] pad_in_i,
  input wire logic [5:0] pad_oe_o,
  input wire logic [5:0] pad_pullup_o,
  input wire logic [5:0] pin_change_o,
  input wire logic       ext_reset_n_o
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  wire lvl_rd = io_rd_i && io_addr_i == 6'h16;
  pud_override_a: assert property (global_pullup_disable_i
    |-> pad_pullup_o == 6'h00) else $error("pull-up kept");
  pull_output_a: assert property (
    (pad_pullup_o & pad_oe_o) == 6'h00) else $error("pull-up on output");
  reset_pad_a: assert property (!pad_pullup_o[5] &&
    (reset_pin_disable_fuse_i || !pad_oe_o[5])) else $error("pad five");
  ext_reset_a: assert property (ext_reset_n_o ==
    (reset_pin_disable_fuse_i || pad_in_i[5])) else $error("ext reset");
  level_read_a: assert property (lvl_rd && !sleep_analog_quiet_i
    |=> io_rdata_o == {2'h0, $past(pad_in_i)}) else $error("level read");
  sleep_read_a: assert property (lvl_rd && sleep_analog_quiet_i
    |=> io_rdata_o[5:2] == 4'h0) else $error("sleep read");
  latch_top_a: assert property (io_rd_i && io_addr_i == 6'h18
    |=> io_rdata_o[7:5] == 3'h0) else $error("latch top bits");
  pin_change_a: assert property ($past(reset_n_i) &&
    !sleep_analog_quiet_i && !$past(sleep_analog_quiet_i)
    |-> pin_change_o == (pad_in_i ^ $past(pad_in_i))) else $error("change");
  cover property (lvl_rd && sleep_analog_quiet_i);
  cover property (pin_change_o != 6'h00);
  cover property (pad_oe_o[5]);
endmodule // sbio_port_asserts
bind sbio_port sbio_port_asserts u_sbio_port_asserts (.*);
`default_nettype wire

// ---- testbench/sbio_pads.sv ----
// external circuitry on the six pads
`timescale 1ns/1ns
`default_nettype none
module sbio_pads (
  input  wire logic       clock_i,
  input  wire logic [5:0] out_i,
  input  wire logic [5:0] oe_i,
  input  wire logic [5:0] pu_i,
  input  wire logic [5:0] en_i,
  input  wire logic [5:0] val_i,
  output var  logic [5:0] level_o
);
  // -----------
  // pad levels
  // -----------
  logic [5:0] last_q = 6'h00;
  always @(posedge clock_i) last_q <= level_o;
  always_comb
    for (int i = 0; i < 6; i++)
      if (oe_i[i]) level_o[i] = (i != 5) && out_i[i];
      else if (en_i[i]) level_o[i] = val_i[i];
      else level_o[i] = pu_i[i] | ~last_q[i]; // floating pad never settles
endmodule // sbio_pads
`default_nettype wire

// ---- testbench/sbio_port_tb.sv ----
// self-checking bench for the six pin port
`timescale 1ns/1ns
`default_nettype none
module sbio_port_tb;
  // -------
  // harness
  // -------
  logic clock_i = '0, reset_n_i = '0, io_wr_i = '0, io_rd_i = '0;
  logic bit_set_instruction_i = '0, bit_clear_instruction_i = '0;
  logic global_pullup_disable_i = '0, reset_pin_disable_fuse_i = '0;
  logic serial_prog_mode_i = '0, sleep_analog_quiet_i = '0;
  logic timer_one_compare_en_i = '0, timer_one_compare_val_i = '0;
  logic serial_data_out_i = '0, serial_data_out_en_i = '0;
  logic [5:0] io_addr_i = '0, en = 6'h3f, val = 6'h20;
  logic [2:0] bit_index_i = '0;
  logic [7:0] io_wdata_i = '0;
  wire [7:0] io_rdata_o;
  wire [5:0] pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o, pin_change_o;
  wire io_hit_o, ext_reset_n_o, ext_irq_zero_input_o, serial_clock_o;
  wire counter_zero_clock_input_o, serial_data_in_o, converter_ref_pin_o;
  wire comparator_pos_input_o, comparator_neg_input_o;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  sbio_port u_sbio_port (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_hit_o(io_hit_o),
    .bit_set_instruction_i(bit_set_instruction_i),
    .bit_clear_instruction_i(bit_clear_instruction_i),
    .bit_index_i(bit_index_i),
    .global_pullup_disable_i(global_pullup_disable_i),
    .reset_pin_disable_fuse_i(reset_pin_disable_fuse_i),
    .serial_prog_mode_i(serial_prog_mode_i),
    .sleep_analog_quiet_i(sleep_analog_quiet_i),
    .timer_one_compare_en_i(timer_one_compare_en_i),
    .timer_one_compare_val_i(timer_one_compare_val_i),
    .serial_data_out_i(serial_data_out_i),
    .serial_data_out_en_i(serial_data_out_en_i),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .pad_pullup_o(pad_pullup_o), .pin_change_o(pin_change_o),
    .ext_reset_n_o(ext_reset_n_o),
    .ext_irq_zero_input_o(ext_irq_zero_input_o),
    .counter_zero_clock_input_o(counter_zero_clock_input_o),
    .serial_clock_o(serial_clock_o), .serial_data_in_o(serial_data_in_o),
    .comparator_pos_input_o(comparator_pos_input_o),
    .comparator_neg_input_o(comparator_neg_input_o),
    .converter_ref_pin_o(converter_ref_pin_o));
  sbio_pads u_sbio_pads (.clock_i(clock_i), .out_i(pad_out_o), .oe_i(pad_oe_o),
    .pu_i(pad_pullup_o), .en_i(en), .val_i(val), .level_o(pad_in_i));
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) if (++cyc > 3000) begin
    n_mismatch++;
    summarize();
  end
  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i) {io_addr_i, io_wdata_i, io_wr_i} <= {a, d, 1'b1};
    @(posedge clock_i) io_wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock_i) {io_addr_i, io_rd_i} <= {a, 1'b1};
    @(posedge clock_i) io_rd_i <= 1'b0;
    #1 chk("rdata", io_rdata_o, e);
  endtask
  task bop(input logic [5:0] a, input logic [2:0] i, input logic s);
    @(posedge clock_i) {io_addr_i, bit_index_i} <= {a, i};
    {bit_set_instruction_i, bit_clear_instruction_i} <= {s, !s};
    @(posedge clock_i) {bit_set_instruction_i, bit_clear_instruction_i} <= 2'h0;
  endtask
  // ---------
  // scenarios
  // ---------
  task t_regs;
    rd(6'h17, 8'h00);
    rd(6'h18, 8'h00);
    wr(6'h17, 8'hff);
    wr(6'h16, 8'h00);
    rd(6'h17, 8'h3f);
    wr(6'h18, 8'hff);
    rd(6'h18, 8'h1f);
    rd(6'h21, 8'h00);
  endtask
  task t_bits;
    wr(6'h17, 8'h05);
    bop(6'h17, 3'h3, 1'b1);
    bop(6'h17, 3'h0, 1'b0);
    rd(6'h17, 8'h0c);
  endtask
  task t_drive;
    wr(6'h17, 8'h1f);
    wr(6'h18, 8'h0a);
    chk("oe", pad_oe_o, 8'h1f);
    chk("out", pad_out_o[4:0], 8'h0a);
    rd(6'h16, 8'h2a);
    wr(6'h17, 8'h00);
    wr(6'h18, 8'h1f);
    en <= 6'h20;
    rd(6'h16, 8'h3f);
    global_pullup_disable_i <= 1'b1;
    #1 chk("pullup", pad_pullup_o, 8'h00);
    val <= 6'h00;
    #1 chk("rst", ext_reset_n_o, 8'h00);
  endtask
  task t_pad5;
    en <= 6'h1f;
    reset_pin_disable_fuse_i <= 1'b1;
    wr(6'h17, 8'h20);
    chk("oe5", pad_oe_o, 8'h20);
    rd(6'h16, 8'h00);
  endtask
  task t_alt;
    val <= 6'h3f;
    sleep_analog_quiet_i <= 1'b1;
    rd(6'h16, 8'h03);
    sleep_analog_quiet_i <= 1'b0;
    val <= 6'h05;
    #1 chk("irq0", ext_irq_zero_input_o, 8'h01);
    chk("cnt0", counter_zero_clock_input_o, 8'h01);
    chk("cmpn", comparator_neg_input_o, 8'h00);
    chk("cmpp", {converter_ref_pin_o, comparator_pos_input_o}, 8'h03);
    serial_prog_mode_i <= 1'b1;
    #1 chk("sck", {serial_clock_o, serial_data_in_o}, 8'h03);
  endtask
  task t_misc;
    serial_prog_mode_i <= 1'b0;
    @(posedge clock_i) val <= 6'h07;
    #1 chk("chg", pin_change_o, 8'h02);
    chk("hit", io_hit_o, 8'h01);
    wr(6'h17, 8'h22);
    timer_one_compare_en_i <= 1'b1;
    #1 chk("cmp", pad_out_o[1], 8'h00);
    {serial_prog_mode_i, serial_data_out_i, serial_data_out_en_i} <= 3'h7;
    #1 chk("sdo", {pad_oe_o[1], pad_out_o[1]}, 8'h03);
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs;
    t_bits;
    t_drive;
    t_pad5;
    t_alt;
    t_misc;
    summarize();
  end
endmodule // sbio_port_tb
`default_nettype wire
